// file: hsc_cfg_host.sv
`timescale 1ns/10ps
`default_nettype none
module hsc_cfg_host
(
  input  wire logic       clk_i,
  input  wire logic       cfg_rd_ack_i,
  input  wire logic [7:0] cfg_rdata_i,
  output logic            cfg_wr_o,
  output logic            cfg_rd_o,
  output logic      [7:0] cfg_addr_o,
  output logic      [7:0] cfg_wdata_o
);
  initial
  begin
    cfg_wr_o    = 1'b0;
    cfg_rd_o    = 1'b0;
    cfg_addr_o  = 8'h00;
    cfg_wdata_o = 8'h00;
  end

  // ascii text as utf-16 little endian: low byte first, high byte zero
  function automatic logic [7:0] utf16_byte(string s, int i);
    return i[0] ? 8'h00 : s[i / 2];
  endfunction

  // idle bus shows inverted values so nothing stale can pass for a request
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk_i);
    cfg_wr_o    = 1'b1;
    cfg_addr_o  = a;
    cfg_wdata_o = d;
    @(negedge clk_i);
    cfg_wr_o    = 1'b0;
    cfg_addr_o  = ~a;
    cfg_wdata_o = ~d;
  endtask

  task automatic rd(logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    @(negedge clk_i);
    cfg_rd_o   = 1'b1;
    cfg_addr_o = a;
    @(negedge clk_i);
    cfg_rd_o   = 1'b0;
    cfg_addr_o = ~a;
    for (int n = 0; n < 6 && !ok; n++)
    begin
      @(posedge clk_i);
      #1;
      ok = cfg_rd_ack_i === 1'b1;
    end
    d = cfg_rdata_i;
  endtask
endmodule
`default_nettype wire

// file: hsc_pkg.sv
package hsc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] SERIAL_BASE   = 8'h30;
  localparam logic [7:0] SERIAL_LAST   = 8'h4f;
  localparam logic [7:0] MAKER_BASE    = 8'h50;
  localparam logic [7:0] MAKER_LAST    = 8'h8f;
  localparam logic [7:0] ITEM_BASE     = 8'h90;
  localparam logic [7:0] ITEM_LAST     = 8'hcf;
  localparam logic [7:0] FEATURE_ADDR  = 8'hf0;
  localparam logic [7:0] FEATURE_RESET = 8'h00;
  localparam logic [7:0] TEXT_RESET    = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // text memory: one array for the three strings, indexed from the serial base
  localparam int unsigned TEXT_DEPTH  = 160;
  localparam int unsigned SERIAL_MAX  = 32;
  localparam int unsigned TEXT_MAX    = 64;
  localparam logic [7:0]  SERIAL_SIZE = 8'h20;
  localparam logic [7:0]  MEM_LAST    = 8'h9f;

  // ****************************************************************
  // string descriptor indices
  // ****************************************************************
  localparam logic [7:0] IDX_SERIAL = 8'h01;
  localparam logic [7:0] IDX_ITEM   = 8'h02;
  localparam logic [7:0] IDX_MAKER  = 8'h03;

  // ****************************************************************
  // feature register fields
  // ****************************************************************
  localparam int unsigned FEAT_SPREAD_BIT = 0;
  localparam int unsigned FEAT_DELAY_LSB  = 1;
  localparam int unsigned FEAT_DELAY_MSB  = 3;
  localparam int unsigned FEAT_OUTEN_BIT  = 4;
  localparam logic [7:0]  FEAT_WR_MASK    = 8'h1f;

  typedef struct packed {
    logic [2:0] rsvd;
    logic       indicator_output_enable;
    logic [2:0] power_reenable_delay;
    logic       pll_spread_disable;
  } hsc_feature_t;

  // four indicator lines: usb2 link, usb2 suspend, usb3 link, usb3 suspend
  typedef struct packed {
    logic usb3_suspend;
    logic usb3_link;
    logic usb2_suspend;
    logic usb2_link;
  } hsc_indicator_t;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned DELAY_UNIT_MS = 200;
  localparam int unsigned UNIT_CYCLES   = DELAY_UNIT_MS * (CLK_HZ / 1000);
  localparam int unsigned UNIT_CNT_W    = 25;

  // arbitrary factory serial value, 32 bytes, byte 0 in the low bits
  localparam logic [255:0] FACTORY_SERIAL = {8{32'h5a3c_96e1}};

endpackage

// file: hsc_string_regs.sv
`timescale 1ns/10ps
`default_nettype none

module hsc_string_regs
#(
  parameter int unsigned UNIT_CYCLES = hsc_pkg::UNIT_CYCLES
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       cfg_wr_i,
  input  wire logic       cfg_rd_i,
  input  wire logic [7:0] cfg_addr_i,
  input  wire logic [7:0] cfg_wdata_i,
  output logic      [7:0] cfg_rdata_o,
  output logic            cfg_rd_ack_o,
  output logic            init_busy_o,
  input  wire logic       custom_serial_enable_i,
  input  wire logic       custom_text_enable_i,
  input  wire logic [5:0] serial_text_length_i,
  input  wire logic [6:0] maker_text_length_i,
  input  wire logic [6:0] item_text_length_i,
  input  wire logic       desc_req_i,
  input  wire logic [7:0] desc_index_i,
  input  wire logic [5:0] desc_byte_i,
  output logic            desc_ack_o,
  output logic            desc_present_o,
  output logic      [7:0] desc_data_o,
  input  wire logic [2:0] otp_delay_i,
  input  wire logic       charge_mode_change_i,
  output logic            port_power_switch_ctrl_o,
  input  wire logic [3:0] indicator_i,
  output logic      [3:0] indicator_o,
  output logic      [3:0] indicator_oe_n_o,
  output logic            pll_spread_disable_o
);

  // ****************************************************************
  // reset walk: loads factory serial and clears both strings
  // ****************************************************************
  logic [7:0] init_idx;
  logic       init_run;
  logic [7:0] next_init_idx;
  logic       next_init_run;
  logic [7:0] init_data;

  always_comb
  begin
    next_init_idx = init_idx;
    next_init_run = init_run;
    if (init_run)
    begin
      next_init_idx = init_idx + 8'h01;
      if (init_idx == hsc_pkg::MEM_LAST)
      begin
        next_init_run = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      init_idx <= 8'h00;
      init_run <= 1'b1;
    end
    else
    begin
      init_idx <= next_init_idx;
      init_run <= next_init_run;
    end
  end

  assign init_data = (init_idx < hsc_pkg::SERIAL_SIZE)
                     ? hsc_pkg::FACTORY_SERIAL[{init_idx[4:0], 3'b000} +: 8]
                     : hsc_pkg::TEXT_RESET;

  // ****************************************************************
  // register writes
  // ****************************************************************
  hsc_pkg::hsc_feature_t feature;
  hsc_pkg::hsc_feature_t next_feature;
  logic                  mem_we;
  logic [7:0]            mem_waddr;
  logic [7:0]            mem_wdata;
  logic                  in_serial;
  logic                  in_maker;
  logic                  in_item;
  logic [7:0]            cfg_idx;

  assign in_serial = (cfg_addr_i >= hsc_pkg::SERIAL_BASE) && (cfg_addr_i <= hsc_pkg::SERIAL_LAST);
  assign in_maker  = (cfg_addr_i >= hsc_pkg::MAKER_BASE) && (cfg_addr_i <= hsc_pkg::MAKER_LAST);
  assign in_item   = (cfg_addr_i >= hsc_pkg::ITEM_BASE) && (cfg_addr_i <= hsc_pkg::ITEM_LAST);
  assign cfg_idx   = cfg_addr_i - hsc_pkg::SERIAL_BASE;

  always_comb
  begin
    mem_we    = 1'b0;
    mem_waddr = cfg_idx;
    mem_wdata = cfg_wdata_i;
    if (init_run)
    begin
      mem_we    = 1'b1;
      mem_waddr = init_idx;
      mem_wdata = init_data;
    end
    else if (cfg_wr_i)
    begin
      mem_we = (in_serial && custom_serial_enable_i)
               || in_maker
               || (in_item && custom_text_enable_i);
    end
  end

  always_comb
  begin
    next_feature = feature;
    // writes during the reset walk are dropped so the map stays consistent
    if (cfg_wr_i && !init_run && (cfg_addr_i == hsc_pkg::FEATURE_ADDR))
    begin
      next_feature = hsc_pkg::hsc_feature_t'(cfg_wdata_i & hsc_pkg::FEAT_WR_MASK);
    end
    next_feature.rsvd = 3'b000;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      feature <= hsc_pkg::hsc_feature_t'(hsc_pkg::FEATURE_RESET);
    end
    else
    begin
      feature <= next_feature;
    end
  end

  // ****************************************************************
  // text memory, port a for register reads, port b for descriptors
  // ****************************************************************
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  logic [7:0] desc_idx;

  hsc_text_mem u_mem
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .we_i      (mem_we),
    .waddr_i   (mem_waddr),
    .wdata_i   (mem_wdata),
    .raddr_a_i (cfg_idx),
    .rdata_a_o (rd_a),
    .raddr_b_i (desc_idx),
    .rdata_b_o (rd_b)
  );

  // ****************************************************************
  // register read pipeline, two cycles
  // ****************************************************************
  logic       rd_p1;
  logic [1:0] rd_kind_p1;
  logic [7:0] feat_p1;
  logic       next_rd_ack;
  logic [7:0] next_rdata;

  always_comb
  begin
    next_rd_ack = rd_p1;
    next_rdata  = cfg_rdata_o;
    if (rd_p1)
    begin
      unique case (rd_kind_p1)
        2'd0:    next_rdata = rd_a;
        2'd1:    next_rdata = feat_p1;
        default: next_rdata = hsc_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_p1        <= 1'b0;
      rd_kind_p1   <= 2'd2;
      feat_p1      <= 8'h00;
      cfg_rd_ack_o <= 1'b0;
      cfg_rdata_o  <= 8'h00;
    end
    else
    begin
      rd_p1        <= cfg_rd_i;
      rd_kind_p1   <= (in_serial || in_maker || in_item) ? 2'd0
                    : (cfg_addr_i == hsc_pkg::FEATURE_ADDR) ? 2'd1 : 2'd2;
      feat_p1      <= feature;
      cfg_rd_ack_o <= next_rd_ack;
      cfg_rdata_o  <= next_rdata;
    end
  end

  // ****************************************************************
  // string descriptor fetch, two cycles
  // ****************************************************************
  logic       desc_p1;
  logic       present_p1;
  logic       present;
  logic [7:0] desc_base;

  always_comb
  begin
    present   = 1'b0;
    desc_base = 8'h00;
    if (desc_index_i == hsc_pkg::IDX_SERIAL)
    begin
      // byte below both length and the 32-byte array
      present = ({1'b0, desc_byte_i} < hsc_pkg::SERIAL_SIZE) && (desc_byte_i < serial_text_length_i);
    end
    else if (desc_index_i == hsc_pkg::IDX_ITEM)
    begin
      desc_base = hsc_pkg::ITEM_BASE - hsc_pkg::SERIAL_BASE;
      present   = ({1'b0, desc_byte_i} < item_text_length_i);
    end
    else if (desc_index_i == hsc_pkg::IDX_MAKER)
    begin
      desc_base = hsc_pkg::MAKER_BASE - hsc_pkg::SERIAL_BASE;
      present   = ({1'b0, desc_byte_i} < maker_text_length_i);
    end
  end

  // a zero length fails every byte compare, so the string reads as absent
  assign desc_idx = desc_base + {2'b00, desc_byte_i};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      desc_p1        <= 1'b0;
      present_p1     <= 1'b0;
      desc_ack_o     <= 1'b0;
      desc_present_o <= 1'b0;
      desc_data_o    <= 8'h00;
    end
    else
    begin
      desc_p1        <= desc_req_i;
      present_p1     <= present && !init_run;
      desc_ack_o     <= desc_p1;
      desc_present_o <= desc_p1 && present_p1;
      desc_data_o    <= (desc_p1 && present_p1) ? rd_b : 8'h00;
    end
  end

  // ****************************************************************
  // power switch re-enable after a charging mode change
  // ****************************************************************
  typedef enum logic {PS_ON, PS_WAIT} hsc_ps_state_t;

  localparam int unsigned          UNIT_CNT_W = hsc_pkg::UNIT_CNT_W;
  localparam logic [UNIT_CNT_W-1:0] UNIT_LAST = UNIT_CNT_W'(UNIT_CYCLES - 1);

  hsc_ps_state_t           ps_state;
  hsc_ps_state_t           next_ps_state;
  logic [UNIT_CNT_W-1:0]   unit_cnt;
  logic [UNIT_CNT_W-1:0]   next_unit_cnt;
  logic [3:0]              units_left;
  logic [3:0]              next_units_left;
  logic                    unit_tick;
  logic [2:0]              delay_eff;

  assign delay_eff = (otp_delay_i == 3'b000) ? feature.power_reenable_delay : otp_delay_i;
  assign unit_tick = (ps_state == PS_WAIT) && (unit_cnt == UNIT_LAST);

  always_comb
  begin
    next_ps_state   = ps_state;
    next_unit_cnt   = unit_tick ? '0 : unit_cnt + 1'b1;
    next_units_left = units_left;
    if (charge_mode_change_i)
    begin
      // a new change restarts the full wait
      next_ps_state   = PS_WAIT;
      next_unit_cnt   = '0;
      next_units_left = {1'b0, delay_eff} + 4'h1;
    end
    else
    begin
      unique case (ps_state)
        PS_ON:
        begin
          next_unit_cnt = '0;
        end
        PS_WAIT:
        begin
          if (unit_tick)
          begin
            next_units_left = units_left - 4'h1;
            if (units_left == 4'h1)
            begin
              next_ps_state = PS_ON;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ps_state                 <= PS_ON;
      unit_cnt                 <= '0;
      units_left               <= 4'h0;
      port_power_switch_ctrl_o <= 1'b1;
    end
    else
    begin
      ps_state                 <= next_ps_state;
      unit_cnt                 <= next_unit_cnt;
      units_left               <= next_units_left;
      port_power_switch_ctrl_o <= (next_ps_state == PS_ON);
    end
  end

  // ****************************************************************
  // indicator pads and phy control
  // ****************************************************************
  for (genvar i = 0; i < 4; i++)
  begin : g_ind
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        indicator_o[i]      <= 1'b0;
        indicator_oe_n_o[i] <= 1'b1;
      end
      else
      begin
        indicator_o[i]      <= indicator_i[i];
        indicator_oe_n_o[i] <= !feature.indicator_output_enable;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pll_spread_disable_o <= 1'b0;
      init_busy_o          <= 1'b1;
    end
    else
    begin
      pll_spread_disable_o <= feature.pll_spread_disable;
      init_busy_o          <= next_init_run;
    end
  end

endmodule

`default_nettype wire

// file: hsc_string_regs_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module hsc_string_regs_assertions
#(
  parameter int unsigned UNIT_CYCLES = 10
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       cfg_wr_i,
  input  wire logic       cfg_rd_i,
  input  wire logic [7:0] cfg_addr_i,
  input  wire logic [7:0] cfg_wdata_i,
  input  wire logic [7:0] cfg_rdata_o,
  input  wire logic       cfg_rd_ack_o,
  input  wire logic       init_busy_o,
  input  wire logic [6:0] maker_text_length_i,
  input  wire logic       desc_req_i,
  input  wire logic [7:0] desc_index_i,
  input  wire logic       desc_ack_o,
  input  wire logic       desc_present_o,
  input  wire logic [7:0] desc_data_o,
  input  wire logic       charge_mode_change_i,
  input  wire logic       port_power_switch_ctrl_o,
  input  wire logic [3:0] indicator_i,
  input  wire logic [3:0] indicator_o,
  input  wire logic [3:0] indicator_oe_n_o,
  input  wire logic       pll_spread_disable_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ********
  // longest legal switch-off: field 7 plus one units, counter restarts on a new change
  // ********
  logic [15:0] low_cnt;
  logic [15:0] next_low_cnt;
  always_comb
  begin
    next_low_cnt = (port_power_switch_ctrl_o || charge_mode_change_i) ? 16'h0000 : low_cnt + 16'h0001;
  end
  always_ff @(posedge clk_i)
  begin
    low_cnt <= rst_i ? 16'h0000 : next_low_cnt;
  end

  a_read_answer:
    assert property (cfg_rd_i |-> ##2 cfg_rd_ack_o) else $error("read answer missing");
  a_feature_rsvd:
    assert property (cfg_rd_i && cfg_addr_i == hsc_pkg::FEATURE_ADDR |-> ##2 cfg_rdata_o[7:5] == 3'h0)
      else $error("feature reserved bits not zero");
  a_desc_answer:
    assert property (desc_req_i |-> ##2 desc_ack_o) else $error("descriptor answer missing");
  a_absent_zero:
    assert property (desc_ack_o && !desc_present_o |-> desc_data_o == 8'h00) else $error("absent byte not zero");
  a_bad_index:
    assert property (desc_req_i && !(desc_index_i inside {[8'h01:8'h03]}) |-> ##2 !desc_present_o)
      else $error("unknown index answered");
  a_maker_absent:
    assert property (desc_req_i && desc_index_i == hsc_pkg::IDX_MAKER && maker_text_length_i == 7'h00
      |-> ##2 desc_ack_o && !desc_present_o) else $error("empty maker string answered");
  a_switch_off:
    assert property (charge_mode_change_i |=> !port_power_switch_ctrl_o [*8]) else $error("switch not held off");
  a_switch_bound:
    assert property (low_cnt < 16'(8 * UNIT_CYCLES + 2)) else $error("switch off too long");
  a_drive_copy:
    assert property (!indicator_oe_n_o[0] |-> indicator_o == $past(indicator_i)) else $error("indicator not copied");
  a_oe_follow:
    assert property (cfg_wr_i && !init_busy_o && cfg_addr_i == hsc_pkg::FEATURE_ADDR
      |-> ##2 indicator_oe_n_o == {4{!$past(cfg_wdata_i[4], 2)}}) else $error("output enable not following");
  a_spread_follow:
    assert property (cfg_wr_i && !init_busy_o && cfg_addr_i == hsc_pkg::FEATURE_ADDR
      |-> ##2 pll_spread_disable_o == $past(cfg_wdata_i[0], 2)) else $error("spread disable not following");
endmodule

bind hsc_string_regs hsc_string_regs_assertions #(.UNIT_CYCLES(UNIT_CYCLES)) chk_u
(
  .clk_i, .rst_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_rd_ack_o, .init_busy_o,
  .maker_text_length_i, .desc_req_i, .desc_index_i, .desc_ack_o, .desc_present_o, .desc_data_o,
  .charge_mode_change_i, .port_power_switch_ctrl_o, .indicator_i, .indicator_o, .indicator_oe_n_o,
  .pll_spread_disable_o
);
`default_nettype wire

// file: hsc_text_mem.sv
`timescale 1ns/10ps
`default_nettype none

module hsc_text_mem
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       we_i,
  input  wire logic [7:0] waddr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [7:0] raddr_a_i,
  output logic      [7:0] rdata_a_o,
  input  wire logic [7:0] raddr_b_i,
  output logic      [7:0] rdata_b_o
);

  logic [7:0] mem [hsc_pkg::TEXT_DEPTH];

  // no reset on the array: the owner fills it with a walk after reset
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_a_o <= 8'h00;
      rdata_b_o <= 8'h00;
    end
    else
    begin
      rdata_a_o <= (raddr_a_i <= hsc_pkg::MEM_LAST) ? mem[raddr_a_i] : 8'h00;
      rdata_b_o <= (raddr_b_i <= hsc_pkg::MEM_LAST) ? mem[raddr_b_i] : 8'h00;
    end
  end

endmodule

`default_nettype wire

// file: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ********
  // stimulus, model and design
  // ********
  localparam int UNITS = 10;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cfg_wr_i;
  logic        cfg_rd_i;
  logic [7:0]  cfg_addr_i;
  logic [7:0]  cfg_wdata_i;
  logic [7:0]  cfg_rdata_o;
  logic        cfg_rd_ack_o;
  logic        init_busy_o;
  logic        custom_serial_enable_i = 1'b0;
  logic        custom_text_enable_i = 1'b0;
  logic [5:0]  serial_text_length_i = 6'h18;
  logic [6:0]  maker_text_length_i = 7'h00;
  logic [6:0]  item_text_length_i = 7'h00;
  logic        desc_req_i = 1'b0;
  logic [7:0]  desc_index_i = 8'h00;
  logic [5:0]  desc_byte_i = 6'h00;
  logic        desc_ack_o;
  logic        desc_present_o;
  logic [7:0]  desc_data_o;
  logic [2:0]  otp_delay_i = 3'h0;
  logic        charge_mode_change_i = 1'b0;
  logic        port_power_switch_ctrl_o;
  logic [3:0]  indicator_i = 4'h0;
  logic [3:0]  indicator_o;
  logic [3:0]  indicator_oe_n_o;
  logic        pll_spread_disable_o;
  logic [31:0] seed = 32'h9cc5;
  int          mem [160];
  int          feat;
  int          checked = 0;
  int          mismatches = 0;
  int          lens [3] = '{0, 5, 70};
  int          slen [3] = '{24, 0, 40};
  int          ov [3] = '{0, 3, 7};
  logic [7:0]  probe [8] = '{8'h30, 8'h3f, 8'h4f, 8'h50, 8'hcf, 8'hf0, 8'hd0, 8'hff};

  always #4 clk_i = ~clk_i;

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  always @(negedge clk_i)
  begin
    seed        <= lfsr(seed);
    indicator_i <= seed[3:0];
  end

  hsc_cfg_host host
  (
    .clk_i(clk_i), .cfg_rd_ack_i(cfg_rd_ack_o), .cfg_rdata_i(cfg_rdata_o), .cfg_wr_o(cfg_wr_i),
    .cfg_rd_o(cfg_rd_i), .cfg_addr_o(cfg_addr_i), .cfg_wdata_o(cfg_wdata_i)
  );

  hsc_string_regs #(.UNIT_CYCLES(UNITS)) dut_u
  (
    .clk_i, .rst_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_rd_ack_o, .init_busy_o,
    .custom_serial_enable_i, .custom_text_enable_i, .serial_text_length_i, .maker_text_length_i,
    .item_text_length_i, .desc_req_i, .desc_index_i, .desc_byte_i, .desc_ack_o, .desc_present_o, .desc_data_o,
    .otp_delay_i, .charge_mode_change_i, .port_power_switch_ctrl_o, .indicator_i, .indicator_o,
    .indicator_oe_n_o, .pll_spread_disable_o
  );

  // ********
  // comparison and reporting
  // ********
  task automatic tally(logic [31:0] got, logic [31:0] exp, bit bad);
    checked++;
    if (bad)
    begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_reg(logic [7:0] got, logic [7:0] exp);
    tally(32'(got), 32'(exp), got !== exp);
  endtask
  task automatic cmp_desc(logic [8:0] got, logic [8:0] exp);
    tally(32'(got), 32'(exp), got !== exp);
  endtask
  task automatic cmp_pin(logic [3:0] got, logic [3:0] exp);
    tally(32'(got), 32'(exp), got !== exp);
  endtask
  task automatic cmp_wait(logic [31:0] got, logic [31:0] exp);
    tally(got, exp, got !== exp);
  endtask
  task automatic close_out;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic fail_wait;
    tally(32'h0, 32'h1, 1'b1);
    close_out;
  endtask

  // ********
  // model of the register bank and bus helpers
  // ********
  function automatic logic [7:0] exp_rd(int a);
    if (a >= 48 && a <= 207)
      return mem[a - 48][7:0];
    return a == 240 ? feat[7:0] : 8'h00;
  endfunction

  function automatic logic [8:0] exp_desc(int idx, int b);
    int len;
    int base;
    len  = idx == 1 ? (serial_text_length_i > 32 ? 32 : serial_text_length_i) :
           idx == 2 ? item_text_length_i : idx == 3 ? maker_text_length_i : 0;
    len  = len > 64 ? 64 : len;
    base = idx == 1 ? 0 : idx == 2 ? 96 : 32;
    return b < len ? {1'b1, mem[base + b][7:0]} : 9'h000;
  endfunction

  task automatic reg_wr(int a, int d);
    host.wr(a[7:0], d[7:0]);
    if ((a >= 48 && a <= 79 && custom_serial_enable_i) || (a >= 80 && a <= 143)
        || (a >= 144 && a <= 207 && custom_text_enable_i))
      mem[a - 48] = d & 255;
    else if (a == 240)
      feat = d & 31;
  endtask

  task automatic reg_rd_chk(int a);
    logic [7:0] d;
    bit         ok;
    host.rd(a[7:0], d, ok);
    if (!ok)
      fail_wait;
    cmp_reg(d, exp_rd(a));
    @(negedge clk_i);
  endtask

  task automatic load_text(int base, string s);
    for (int i = 0; i < 2 * s.len(); i++)
      reg_wr(base + i, int'(host.utf16_byte(s, i)));
  endtask

  task automatic desc_chk(int idx, int b);
    @(negedge clk_i);
    desc_req_i   = 1'b1;
    desc_index_i = idx[7:0];
    desc_byte_i  = b[5:0];
    @(negedge clk_i);
    desc_req_i   = 1'b0;
    desc_index_i = ~idx[7:0];
    for (int n = 0; n < 6 && desc_ack_o !== 1'b1; n++)
    begin
      @(posedge clk_i);
      #1;
    end
    if (desc_ack_o !== 1'b1)
      fail_wait;
    cmp_desc({desc_present_o, desc_data_o}, exp_desc(idx, b));
    @(negedge clk_i);
  endtask

  task automatic sweep(int idx);
    for (int b = 0; b < 64; b++)
      desc_chk(idx, b);
  endtask

  task automatic pin_chk;
    repeat (2) @(posedge clk_i);
    #1;
    cmp_pin(indicator_oe_n_o, feat[4] ? 4'h0 : 4'hf);
    cmp_pin({3'h0, pll_spread_disable_o}, {3'h0, feat[0]});
    if (feat[4])
      cmp_pin(indicator_o, indicator_i);
    @(negedge clk_i);
  endtask

  // counts every low cycle in a window longer than the longest delay, so an early or late return shows
  task automatic switch_chk;
    int n;
    int exp;
    n   = 0;
    exp = ((otp_delay_i != 3'h0 ? int'(otp_delay_i) : (feat >> 1) & 7) + 1) * UNITS;
    charge_mode_change_i = 1'b1;
    // the switch drops at the taking edge itself, so that edge is counted too
    @(posedge clk_i);
    #1;
    n += int'(port_power_switch_ctrl_o === 1'b0);
    @(negedge clk_i);
    charge_mode_change_i = 1'b0;
    repeat (199)
    begin
      @(posedge clk_i);
      #1;
      n += int'(port_power_switch_ctrl_o === 1'b0);
    end
    cmp_wait(n, exp);
    cmp_pin({3'h0, port_power_switch_ctrl_o}, 4'h1);
    @(negedge clk_i);
  endtask

  // ********
  // scenarios
  // ********
  initial
  begin
    for (int i = 0; i < 160; i++)
      mem[i] = i < 32 ? int'(hsc_pkg::FACTORY_SERIAL[8*i +: 8]) : 0;
    feat = 0;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    for (int n = 0; n < 400 && init_busy_o !== 1'b0; n++)
      @(negedge clk_i);
    if (init_busy_o !== 1'b0)
      fail_wait;
    foreach (probe[k])
      reg_rd_chk(probe[k]);
    $display("test reset done");
    reg_wr(48, 165);
    reg_rd_chk(48);
    custom_serial_enable_i = 1'b1;
    for (int i = 48; i < 52; i++)
      reg_wr(i, int'(seed[11:4]));
    reg_rd_chk(49);
    foreach (slen[k])
    begin
      serial_text_length_i = slen[k][5:0];
      sweep(1);
    end
    $display("test serial done");
    load_text(80, "Hub");
    foreach (lens[k])
    begin
      maker_text_length_i = lens[k][6:0];
      sweep(3);
    end
    sweep(0);
    sweep(4);
    load_text(144, "Z");
    custom_text_enable_i = 1'b1;
    load_text(144, "Dock");
    foreach (lens[k])
    begin
      item_text_length_i = lens[k][6:0];
      sweep(2);
    end
    $display("test strings done");
    for (int i = 0; i < 4; i++)
    begin
      reg_wr(240, i < 2 ? 255 * (1 - i) : int'(seed[7:0]));
      reg_rd_chk(240);
      pin_chk;
    end
    $display("test feature done");
    reg_wr(240, 5);
    foreach (ov[k])
    begin
      otp_delay_i = ov[k][2:0];
      switch_chk;
    end
    $display("test power done");
    close_out;
  end
endmodule
`default_nettype wire
